// [inc/cmd_status_pkg.sv]
// Constants, encodings and types shared by the command and status word block.
// Assumes a 100 MHz core clock and 16-bit control block words at byte offsets.
package cmd_status_pkg;

  // ****************************************************************
  // Control block word offsets (byte offsets within a control block)
  // ****************************************************************
  localparam logic [7:0] OFS_FIRST_COMMAND_WORD = 8'h14;
  localparam logic [7:0] OFS_FIRST_STATUS_WORD = 8'h16;
  localparam logic [7:0] OFS_SECOND_COMMAND_WORD = 8'h18;
  localparam logic [7:0] OFS_SECOND_STATUS_WORD = 8'h1a;
  localparam logic [7:0] OFS_STATUS_RESPONSE_TIMES = 8'h1c;
  localparam logic [7:0] OFS_FIRST_STATUS_IRQ_MASK = 8'h1e;
  localparam logic [7:0] OFS_SECOND_STATUS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_LEVEL_A_IRQ_MASK = 8'h22;
  localparam int NUM_WORDS = 8;

  // Word indices inside the local word array
  localparam logic [2:0] IDX_CMD1 = 3'h0;
  localparam logic [2:0] IDX_STAT1 = 3'h1;
  localparam logic [2:0] IDX_CMD2 = 3'h2;
  localparam logic [2:0] IDX_STAT2 = 3'h3;
  localparam logic [2:0] IDX_RESP_TIMES = 3'h4;
  localparam logic [2:0] IDX_STAT1_MASK = 3'h5;
  localparam logic [2:0] IDX_STAT2_MASK = 3'h6;
  localparam logic [2:0] IDX_A_MASK = 3'h7;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ****************************************************************
  // Response time word fields
  // ****************************************************************
  localparam int RESP2_MSB = 15;
  localparam int RESP2_LSB = 8;
  localparam int RESP1_MSB = 7;
  localparam int RESP1_LSB = 0;

  // ****************************************************************
  // Interrupt status word bit positions
  // ****************************************************************
  localparam int ISR_TX_ERROR = 15;
  localparam int ISR_DMA_ERROR = 14;
  localparam int ISR_RING_PAGE_FULL = 13;
  localparam int ISR_END_OF_MESSAGE = 12;
  localparam int ISR_PROG_ERROR = 11;
  localparam int ISR_SW_MASK_HIT = 10;
  localparam int ISR_RING_FULL = 10;
  localparam int ISR_STOP = 9;
  localparam int ISR_LOCK_LOST = 8;
  localparam int ISR_ILLEGAL_CMD = 7;
  localparam int ISR_TRIGGER = 6;
  localparam int ISR_MODE_CODE = 5;
  localparam int ISR_RETRY_OK = 4;
  localparam int ISR_RETRY_FAILED = 3;
  localparam int ISR_BUS_SWITCH = 3;
  localparam int ISR_SELFTEST_FAIL = 2;
  localparam int ISR_SELFTEST_CMP = 1;
  localparam int ISR_SECONDARY_BUS = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int DEFAULT_RESP_US = 4;
  localparam int ADVISED_MIN_RESP_US = 5;
  localparam int SYNC_LEAD_NS = 1500;
  localparam logic [15:0] CYC_PER_US = 16'(CLK_MHZ);
  localparam logic [15:0] DEFAULT_RESP_CYC = 16'(DEFAULT_RESP_US * CLK_MHZ);
  localparam logic [15:0] SYNC_LEAD_CYC = 16'((SYNC_LEAD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ****************************************************************
  // Address widths
  // ****************************************************************
  localparam int DATA_ADDR_W = 18;
  localparam int MAP_USED_W = 2;

  // ****************************************************************
  // Message sequencer states
  // ****************************************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD1 = 8'h02,
    ST_CMD2 = 8'h04,
    ST_STAT2 = 8'h08,
    ST_DATA1 = 8'h10,
    ST_STAT1 = 8'h20,
    ST_DATA2 = 8'h40,
    ST_END = 8'h80
  } seq_state_t;

endpackage : cmd_status_pkg

// [src/resp_delay_timer.sv]
// Response delay timer: counts cycles since the last mid-parity point.
// Assumes the codec pulses parity_mid at the middle of every word's parity bit.
`timescale 1ns/1ps
module resp_delay_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Timing reference and programmed time
  input wire logic parity_mid,
  input wire logic [7:0] resp_us,
  // Start point for the status word
  output logic due
);

  typedef struct packed {
    logic [15:0] count;
  } timer_state_t;

  timer_state_t state_ff;
  timer_state_t nxt_state;
  logic [15:0] target_cyc;
  logic [15:0] sync_cyc;

  // Mid-parity to mid-sync time, zero selects the default
  always_comb begin
    sync_cyc = (resp_us == 8'h00) ? cmd_status_pkg::DEFAULT_RESP_CYC :
               16'(resp_us * cmd_status_pkg::CYC_PER_US);
    if (sync_cyc > cmd_status_pkg::SYNC_LEAD_CYC) begin
      target_cyc = sync_cyc - cmd_status_pkg::SYNC_LEAD_CYC;
    end else begin
      target_cyc = 16'h0001;
    end
  end

  // Saturating count restarted at each mid-parity point
  always_comb begin
    nxt_state = state_ff;
    if (parity_mid) begin
      nxt_state.count = cmd_status_pkg::COUNT_RESET;
    end else if (state_ff.count != 16'hffff) begin
      nxt_state.count = state_ff.count + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign due = (state_ff.count >= target_cyc) && !parity_mid;

endmodule : resp_delay_timer

// [src/cmd_status_words.sv]
// Bus controller command and status words of one control block.
// Operation
// - First command word always goes out first on the bus.
// - With the RT-RT flag set, second command word follows as transmit command.
// - Command words go out exactly as stored, no field altered.
// - Count, direction and RT-RT come from control inputs, not commands.
// - Received status stored unchanged; first to first slot, transmitter's to second.
// - No response leaves the status location untouched.
// - Host loads simulated status words; device transmits stored values.
// - Status simulation per response only when control word enables it.
// - Simulated response data uses address from data pointer and map.
// - Upper byte times second status, lower byte times first status.
// - Simulated response timed from mid parity to mid sync.
// - Zero response time defaults to 4 microseconds.
// - Status mask ones matching status ones request an interrupt.
// - At message end A mask ANDed with interrupt status raises interrupt.
// - Hardware interrupt line driven only while hardware enable is set.
// - Mask bits follow the interrupt status layout from bit 15 to 0.
// - Bits 10 and 3 are shared; bits 4, 2, 1 as the status layout.
// - Interrupt status posted only when nonzero unless posting always.
// - Data address is pointer plus map, 18 of 20 bits used.
// Assumes an external word codec, data mover and message-end logic.
`timescale 1ns/1ps
module cmd_status_words (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control block word port
  input wire logic [7:0] cb_addr,
  input wire logic cb_wr,
  input wire logic cb_rd,
  input wire logic [15:0] cb_wdata,
  output logic [15:0] cb_rdata,
  output logic cb_rvalid,
  // Message control from the control word locations
  input wire logic msg_start,
  input wire logic ctrl_rt_rt,
  input wire logic ctrl_bc_to_rt,
  input wire logic ctrl_sim_first,
  input wire logic ctrl_sim_second,
  input wire logic [5:0] ctrl_word_count,
  input wire logic [15:0] data_pointer,
  input wire logic [3:0] data_map,
  input wire logic post_always,
  input wire logic hw_irq_enable,
  output logic busy,
  // Word transmitter
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [15:0] tx_word,
  // Word receiver
  input wire logic parity_mid,
  input wire logic rx_status_valid,
  input wire logic [15:0] rx_status_word,
  input wire logic no_response,
  // Data word mover
  output logic data_start,
  output logic [17:0] data_addr,
  output logic [5:0] data_count,
  input wire logic data_done,
  // Message end and interrupt
  input wire logic msg_end,
  input wire logic [15:0] interrupt_status_word,
  output logic isr_post_valid,
  output logic [15:0] isr_post_word,
  output logic irq_request,
  output logic irq_line
);

  typedef struct packed {
    logic [cmd_status_pkg::NUM_WORDS-1:0][15:0] words;
    cmd_status_pkg::seq_state_t seq;
    logic [15:0] rdata;
    logic rvalid;
    logic [15:0] tx_word;
    logic data_start;
    logic [17:0] data_addr;
    logic [5:0] data_count;
    logic rt_rt;
    logic bc_to_rt;
    logic sim_first;
    logic sim_second;
    logic sw_hit;
    logic post_valid;
    logic [15:0] post_word;
    logic irq_request;
    logic irq_line;
  } blk_state_t;

  blk_state_t state_ff;
  blk_state_t nxt_state;

  // ****************************************************************
  // Local decode
  // ****************************************************************
  logic addr_hit;
  logic [2:0] addr_idx;
  logic [7:0] addr_rel;
  logic in_stat1;
  logic in_stat2;
  logic slot_sim;
  logic [7:0] slot_resp_us;
  logic resp_due;
  logic [15:0] isr_eff;
  logic a_hit;

  // Word select from byte offset, word aligned only
  always_comb begin
    addr_rel = cb_addr - cmd_status_pkg::OFS_FIRST_COMMAND_WORD;
    addr_idx = addr_rel[3:1];
    addr_hit = (cb_addr >= cmd_status_pkg::OFS_FIRST_COMMAND_WORD) &&
               (cb_addr <= cmd_status_pkg::OFS_LEVEL_A_IRQ_MASK) && !cb_addr[0];
  end

  // Status slot in progress and its timing byte
  always_comb begin
    in_stat1 = (state_ff.seq == cmd_status_pkg::ST_STAT1);
    in_stat2 = (state_ff.seq == cmd_status_pkg::ST_STAT2);
    slot_sim = (in_stat1 && state_ff.sim_first) || (in_stat2 && state_ff.sim_second);
    slot_resp_us = in_stat2 ?
      state_ff.words[cmd_status_pkg::IDX_RESP_TIMES][cmd_status_pkg::RESP2_MSB:cmd_status_pkg::RESP2_LSB] :
      state_ff.words[cmd_status_pkg::IDX_RESP_TIMES][cmd_status_pkg::RESP1_MSB:cmd_status_pkg::RESP1_LSB];
  end

  // ****************************************************************
  // Simulated response timing
  // ****************************************************************
  resp_delay_timer u_resp_timer (
    .core_clk(core_clk),
    .reset(reset),
    .parity_mid(parity_mid),
    .resp_us(slot_resp_us),
    .due(resp_due)
  );

  // Transmit request: commands at once, simulated status when due
  always_comb begin
    tx_valid = (state_ff.seq == cmd_status_pkg::ST_CMD1) ||
               (state_ff.seq == cmd_status_pkg::ST_CMD2) ||
               (slot_sim && resp_due);
  end

  // ****************************************************************
  // Message end interrupt evaluation
  // ****************************************************************
  always_comb begin
    isr_eff = interrupt_status_word;
    if (state_ff.sw_hit) begin
      isr_eff[cmd_status_pkg::ISR_SW_MASK_HIT] = 1'b1;
    end
    a_hit = |(isr_eff & state_ff.words[cmd_status_pkg::IDX_A_MASK]);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rvalid = 1'b0;
    nxt_state.data_start = 1'b0;
    nxt_state.post_valid = 1'b0;
    nxt_state.irq_request = 1'b0;
    nxt_state.irq_line = 1'b0;

    // Host access to the control block words
    if (cb_wr && addr_hit) begin
      nxt_state.words[addr_idx] = cb_wdata;
    end
    if (cb_rd) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = addr_hit ? state_ff.words[addr_idx] : 16'h0000;
    end

    case (state_ff.seq)
      cmd_status_pkg::ST_IDLE: begin
        if (msg_start) begin
          nxt_state.rt_rt = ctrl_rt_rt;
          nxt_state.bc_to_rt = ctrl_bc_to_rt;
          nxt_state.sim_first = ctrl_sim_first;
          nxt_state.sim_second = ctrl_sim_second && ctrl_rt_rt;
          nxt_state.data_count = ctrl_word_count;
          nxt_state.data_addr = {data_map[cmd_status_pkg::MAP_USED_W-1:0], data_pointer};
          nxt_state.sw_hit = 1'b0;
          nxt_state.tx_word = state_ff.words[cmd_status_pkg::IDX_CMD1];
          nxt_state.seq = cmd_status_pkg::ST_CMD1;
        end
      end
      cmd_status_pkg::ST_CMD1: begin
        if (tx_ready) begin
          if (state_ff.rt_rt) begin
            nxt_state.tx_word = state_ff.words[cmd_status_pkg::IDX_CMD2];
            nxt_state.seq = cmd_status_pkg::ST_CMD2;
          end else if (state_ff.bc_to_rt) begin
            nxt_state.data_start = 1'b1;
            nxt_state.seq = cmd_status_pkg::ST_DATA1;
          end else begin
            nxt_state.tx_word = state_ff.words[cmd_status_pkg::IDX_STAT1];
            nxt_state.seq = cmd_status_pkg::ST_STAT1;
          end
        end
      end
      cmd_status_pkg::ST_CMD2: begin
        if (tx_ready) begin
          nxt_state.tx_word = state_ff.words[cmd_status_pkg::IDX_STAT2];
          nxt_state.seq = cmd_status_pkg::ST_STAT2;
        end
      end
      cmd_status_pkg::ST_STAT2: begin
        if (slot_sim) begin
          if (resp_due && tx_ready) begin
            nxt_state.data_start = 1'b1;
            nxt_state.seq = cmd_status_pkg::ST_DATA1;
          end
        end else if (rx_status_valid) begin
          nxt_state.words[cmd_status_pkg::IDX_STAT2] = rx_status_word;
          if (|(rx_status_word & state_ff.words[cmd_status_pkg::IDX_STAT2_MASK])) begin
            nxt_state.sw_hit = 1'b1;
          end
          nxt_state.data_start = 1'b1;
          nxt_state.seq = cmd_status_pkg::ST_DATA1;
        end else if (no_response) begin
          nxt_state.seq = cmd_status_pkg::ST_END;
        end
      end
      cmd_status_pkg::ST_DATA1: begin
        if (data_done) begin
          nxt_state.tx_word = state_ff.words[cmd_status_pkg::IDX_STAT1];
          nxt_state.seq = cmd_status_pkg::ST_STAT1;
        end
      end
      cmd_status_pkg::ST_STAT1: begin
        if (slot_sim) begin
          if (resp_due && tx_ready) begin
            nxt_state.data_start = !(state_ff.rt_rt || state_ff.bc_to_rt);
            nxt_state.seq = (state_ff.rt_rt || state_ff.bc_to_rt) ?
                            cmd_status_pkg::ST_END : cmd_status_pkg::ST_DATA2;
          end
        end else if (rx_status_valid) begin
          nxt_state.words[cmd_status_pkg::IDX_STAT1] = rx_status_word;
          if (|(rx_status_word & state_ff.words[cmd_status_pkg::IDX_STAT1_MASK])) begin
            nxt_state.sw_hit = 1'b1;
          end
          nxt_state.data_start = !(state_ff.rt_rt || state_ff.bc_to_rt);
          nxt_state.seq = (state_ff.rt_rt || state_ff.bc_to_rt) ?
                          cmd_status_pkg::ST_END : cmd_status_pkg::ST_DATA2;
        end else if (no_response) begin
          nxt_state.seq = cmd_status_pkg::ST_END;
        end
      end
      cmd_status_pkg::ST_DATA2: begin
        if (data_done) begin
          nxt_state.seq = cmd_status_pkg::ST_END;
        end
      end
      cmd_status_pkg::ST_END: begin
        if (msg_end) begin
          nxt_state.post_word = isr_eff;
          nxt_state.post_valid = post_always || (isr_eff != 16'h0000);
          nxt_state.irq_request = a_hit || state_ff.sw_hit;
          nxt_state.irq_line = (a_hit || state_ff.sw_hit) && hw_irq_enable;
          nxt_state.seq = cmd_status_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state.seq = cmd_status_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= '0;
      state_ff.seq <= cmd_status_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs from the state register
  assign cb_rdata = state_ff.rdata;
  assign cb_rvalid = state_ff.rvalid;
  assign busy = (state_ff.seq != cmd_status_pkg::ST_IDLE);
  assign tx_word = state_ff.tx_word;
  assign data_start = state_ff.data_start;
  assign data_addr = state_ff.data_addr;
  assign data_count = state_ff.data_count;
  assign isr_post_valid = state_ff.post_valid;
  assign isr_post_word = state_ff.post_word;
  assign irq_request = state_ff.irq_request;
  assign irq_line = state_ff.irq_line;

endmodule : cmd_status_words

// [tb/cmd_status_words_asserts.sv]
// Port checks for the command and status word block.
// Assumes msg_end is only pulsed while a message waits at its end.
`timescale 1ns/1ps
module cmd_status_words_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] cb_addr,
  input wire logic cb_wr,
  input wire logic cb_rd,
  input wire logic [15:0] cb_wdata,
  input wire logic [15:0] cb_rdata,
  input wire logic cb_rvalid,
  // Message ports
  input wire logic msg_start,
  input wire logic [15:0] data_pointer,
  input wire logic [3:0] data_map,
  input wire logic busy,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [15:0] tx_word,
  input wire logic data_start,
  input wire logic [17:0] data_addr,
  // Message end
  input wire logic msg_end,
  input wire logic [15:0] interrupt_status_word,
  input wire logic hw_irq_enable,
  input wire logic isr_post_valid,
  input wire logic irq_request,
  input wire logic irq_line
);
  logic [15:0] cmd_ff, amask_ff;
  logic [17:0] addr_ff;
  // Shadows of host words and sampled data address
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {cmd_ff, amask_ff, addr_ff} <= '0;
    end else begin
      if (cb_wr && cb_addr == 8'h14) cmd_ff <= cb_wdata;
      if (cb_wr && cb_addr == 8'h22) amask_ff <= cb_wdata;
      if (msg_start && !busy) addr_ff <= {data_map[1:0], data_pointer};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ****************************************
  // Assertions
  // ****************************************
  a_first_cmd: assert property (msg_start && !busy |=> tx_valid && tx_word == cmd_ff) else $error("bad first");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word)) else $error("tx moved");
  a_rd_answer: assert property (cb_rd |=> cb_rvalid) else $error("no read answer");
  a_rd_unmapped: assert property (cb_rd && (cb_addr[0] || cb_addr > 8'h22 || cb_addr < 8'h14)
    |=> cb_rdata == 16'h0000) else $error("unmapped read");
  a_data_addr: assert property (data_start |-> data_addr == addr_ff) else $error("bad address");
  a_amask_irq: assert property (msg_end && busy && (amask_ff & interrupt_status_word) != 16'h0000
    |=> irq_request) else $error("a mask missed");
  a_irq_gate: assert property (irq_line == (irq_request && $past(hw_irq_enable))) else $error("gate");
  a_irq_end: assert property (irq_request || isr_post_valid |-> $past(msg_end)) else $error("stray end");
  a_post_nz: assert property (msg_end && busy && interrupt_status_word != 16'h0000
    |=> isr_post_valid) else $error("no post");
  a_busy_run: assert property (msg_start && !busy |=> busy [*2]) else $error("busy short");
  c_irq_line: cover property (irq_line);
  c_post_quiet: cover property (isr_post_valid && !irq_request);
  c_data: cover property (data_start);
endmodule : cmd_status_words_asserts
bind cmd_status_words cmd_status_words_asserts cmd_status_words_asserts_i (.*);

// [tb/rt_partner.sv]
// Remote terminal model: takes words, answers status, moves data.
// Assumes the bench enables answers only for received status slots.
`timescale 1ns/1ps
module rt_partner (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Bench control
  input wire logic answer_en,
  input wire logic silent,
  input wire logic [15:0] answer_word,
  input wire logic [15:0] answer_alt,
  // Device side
  input wire logic tx_valid,
  input wire logic data_start,
  output logic tx_ready,
  output logic parity_mid,
  output logic rx_status_valid,
  output logic [15:0] rx_status_word,
  output logic no_response,
  output logic data_done
);
  int wait_cnt, data_cnt;
  logic after_data;
  // Accept with random stalls, answer slot, data phase
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {tx_ready, parity_mid, rx_status_valid, no_response, data_done, after_data} <= '0;
      rx_status_word <= 16'hffff;
      wait_cnt <= 0;
      data_cnt <= 0;
    end else begin
      tx_ready <= tx_valid && !tx_ready && ($urandom_range(2) == 0);
      parity_mid <= (tx_valid && tx_ready) || data_cnt == 1;
      data_done <= data_cnt == 1;
      data_cnt <= data_start ? 4 : (data_cnt > 0 ? data_cnt - 1 : 0);
      if ((tx_valid && tx_ready) || data_cnt == 1) begin
        wait_cnt <= 8;
        after_data <= data_cnt == 1;
      end else if (tx_valid || data_start) begin
        wait_cnt <= 0;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end
      rx_status_valid <= answer_en && !silent && wait_cnt == 1 && !tx_valid;
      no_response <= answer_en && silent && wait_cnt == 1 && !tx_valid;
      // Idle word changes every cycle
      rx_status_word <= (wait_cnt == 1) ? (after_data ? answer_alt : answer_word) : ~rx_status_word;
    end
  end
endmodule : rt_partner

// [tb/tb_top.sv]
// Self-checking bench for the command and status word block.
// Assumes the remote terminal model on the word ports.
`timescale 1ns/1ps
module tb_top;
  logic core_clk, reset, cb_wr, cb_rd, cb_rvalid, msg_start, ctrl_rt_rt, ctrl_bc_to_rt;
  logic ctrl_sim_first, ctrl_sim_second, post_always, hw_irq_enable, busy, tx_valid, tx_ready;
  logic parity_mid, rx_status_valid, no_response, data_start, data_done, msg_end;
  logic isr_post_valid, irq_request, irq_line, answer_en, silent, tv_d, me_d;
  logic [7:0] cb_addr;
  logic [5:0] ctrl_word_count, data_count;
  logic [3:0] data_map;
  logic [17:0] data_addr;
  logic [15:0] cb_wdata, cb_rdata, data_pointer, tx_word, rx_status_word, s;
  logic [15:0] interrupt_status_word, isr_post_word, answer_word, answer_alt;
  logic [15:0] v[8];
  logic [15:0] rd_q[$];
  logic [31:0] tx_q[$], e;
  logic [23:0] dat_q[$];
  logic [18:0] end_q[$];
  int fail_count, comparisons, cycles, events, gap, seen, i;

  cmd_status_words cmd_status_words_i (.*);
  rt_partner rt_partner_i (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task end_sim;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1 {cb_addr, cb_wdata, cb_wr} = {a, d, 1'b1};
    @(posedge core_clk);
    #1 cb_wr = 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] x);
    rd_q.push_back(x);
    @(posedge core_clk);
    #1 {cb_addr, cb_rd} = {a, 1'b1};
    @(posedge core_clk);
    #1 cb_rd = 1'b0;
  endtask : rd

  task prog;
    for (int k = 0; k < 8; k++) wr(8'h14 + 8'(2 * k), v[k]);
  endtask : prog

  // Cycles from mid parity to word start, 100 per microsecond
  function int gapf(input logic [7:0] b);
    return (b == 8'h00) ? 250 : b * 100 - 150;
  endfunction : gapf

  task run(input logic rt, b2r, sf, ss, dat, input int n, input logic [15:0] isw, pw, input logic hit);
    logic irq, pv;
    irq = hit || ((v[7] & pw) != 16'h0000);
    pv = pw != 16'h0000 || post_always;
    @(posedge core_clk);
    #1 {ctrl_rt_rt, ctrl_bc_to_rt, ctrl_sim_first, ctrl_sim_second} = {rt, b2r, sf, ss};
    {data_pointer, data_map, ctrl_word_count} = 26'($urandom);
    tx_q.push_back({16'h0000, v[0]});
    if (rt) tx_q.push_back({16'h0000, v[2]});
    if (ss) tx_q.push_back({16'(gapf(v[4][15:8])), v[3]});
    if (sf) tx_q.push_back({16'(gapf(v[4][7:0])), v[1]});
    if (dat) dat_q.push_back({data_map[1:0], data_pointer, ctrl_word_count});
    end_q.push_back({pv, pv ? pw : 16'h0000, irq, irq && hw_irq_enable});
    events = 0;
    msg_start = 1'b1;
    @(posedge core_clk);
    #1 msg_start = 1'b0;
    while (events < n) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    #1 {msg_end, interrupt_status_word} = {1'b1, isw};
    @(posedge core_clk);
    #1 {msg_end, interrupt_status_word} = {1'b0, ~isw};
    repeat (12) @(posedge core_clk);
  endtask : run

  // Result watcher: compares each result with the oldest note
  always @(posedge core_clk) begin
    if (!reset) begin
      gap = parity_mid ? 0 : gap + 1;
      if (tx_valid && !tv_d) seen = gap;
      if (tx_valid && tx_ready) begin
        e = tx_q.size() > 0 ? tx_q.pop_front() : 32'hxxxxxxxx;
        chk(tx_word, e[15:0], "word");
        if (e[31:16] != 16'h0000) chk(seen + 1 >= e[31:16] && seen <= e[31:16] + 2, 1, "gap");
        events++;
      end
      if (rx_status_valid || no_response || data_done) events++;
      if (cb_rvalid) chk(cb_rdata, rd_q.size() > 0 ? rd_q.pop_front() : 16'hxxxx, "read");
      if (data_start) chk({data_addr, data_count}, dat_q.size() > 0 ? dat_q.pop_front() : 24'hx, "data");
      if (me_d || isr_post_valid || irq_request || irq_line)
        chk({isr_post_valid, isr_post_valid ? isr_post_word : 16'h0000, irq_request, irq_line},
          end_q.size() > 0 ? end_q.pop_front() : 19'hx, "end");
    end
    tv_d = tx_valid;
    me_d = msg_end;
    cycles++;
    if (cycles == 20000) begin
      chk(0, 1, "timeout");
      end_sim();
    end
  end

  initial begin
    {cb_addr, cb_wr, cb_rd, cb_wdata, msg_start, ctrl_rt_rt, ctrl_bc_to_rt, ctrl_sim_first} = '0;
    {ctrl_sim_second, ctrl_word_count, data_pointer, data_map, post_always, hw_irq_enable} = '0;
    {msg_end, interrupt_status_word, answer_en, silent, answer_word, answer_alt} = '0;
    reset = 1'b1;
    repeat (20) @(posedge core_clk);
    #1 reset = 1'b0;
    void'($urandom(32'h3284b328));
    // Reset values, read back, unmapped places
    for (i = 0; i < 8; i++) rd(8'h14 + 8'(2 * i), 16'h0000);
    for (i = 0; i < 8; i++) v[i] = 16'($urandom);
    prog();
    for (i = 0; i < 8; i++) rd(8'h14 + 8'(2 * i), v[i]);
    rd(8'h15, 16'h0000);
    rd(8'h24, 16'h0000);
    $display("Test registers done");
    {v[5], v[6], v[7]} = {16'h0800, 16'h0000, 16'h0000};
    prog();
    s = 16'($urandom) | 16'h0800;
    {answer_word, answer_en, hw_irq_enable} = {s, 2'b11};
    run(0, 0, 0, 0, 1, 3, 16'h0000, 16'h0400, 1'b1);
    rd(8'h16, s);
    $display("Test received status done");
    {v[5], v[6]} = {16'h0000, 16'h0800};
    prog();
    answer_alt = 16'($urandom);
    run(1, 0, 0, 0, 1, 5, 16'h1000, 16'h1400, 1'b1);
    rd(8'h1a, s);
    rd(8'h16, answer_alt);
    answer_alt = 16'($urandom);
    run(0, 1, 0, 0, 1, 3, 16'h0000, 16'h0000, 1'b0);
    rd(8'h16, answer_alt);
    $display("Test two terminals done");
    v[5] = 16'hffff;
    prog();
    silent = 1'b1;
    run(0, 0, 0, 0, 0, 2, 16'h0000, 16'h0000, 1'b0);
    rd(8'h16, v[1]);
    $display("Test no response done");
    {v[4], v[5], v[6]} = {16'h0500, 32'h0};
    prog();
    {answer_en, silent, post_always} = 3'b001;
    run(1, 0, 1, 1, 1, 5, 16'h0000, 16'h0000, 1'b0);
    $display("Test simulated status done");
    {answer_en, silent} = 2'b11;
    for (i = 0; i <= 16; i++) begin
      v[7] = 16'($urandom);
      wr(8'h22, v[7]);
      {post_always, hw_irq_enable} = 2'($urandom);
      s = (i < 16) ? 16'h0001 << i : 16'h0000;
      run(0, 0, 0, 0, 0, 2, s, s, 1'b0);
    end
    $display("Test interrupt mask done");
    chk(tx_q.size() + dat_q.size() + end_q.size() + rd_q.size(), 0, "left over");
    end_sim();
  end
endmodule : tb_top
